// ===== rtl/sacpd_core.sv
// Conversion and power-mode control of a 12-bit serial converter.
// Assumes the host drives cs_b and sclk; sclk stops between frames.
// Assumes sample_code comes from the sampler on clk_sys.
`timescale 1ns/1ps

module sacpd_core #(
    parameter int DEPTH = sacpd_pkg::FIFO_DEPTH
) (
    input  wire logic                            clk_sys,
    input  wire logic                            rst_b,
    input  wire logic                            sclk,
    input  wire logic                            cs_b,
    input  wire logic [sacpd_pkg::RES_BITS-1:0]  sample_code,
    input  wire logic                            result_ready,
    output logic                                 result_valid,
    output sacpd_pkg::sacpd_result_s             result_data,
    output logic                                 serial_data_out,
    output logic                                 serial_data_oe_b,
    output logic                                 power_on,
    output logic                                 power_ready,
    output sacpd_pkg::sacpd_mode_e               power_mode,
    output logic                                 conv_overrun,
    output logic                                 rate_err
);

    localparam int CW = sacpd_pkg::CNT_W;
    localparam int RW = sacpd_pkg::RES_BITS;
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Gray to binary, used on both synchronised counts
    function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        b[CW-1] = g[CW-1];
        for (int i = CW - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Buffer pointer advance with wrap
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1))
        begin
            return '0;
        end
        return p + 1'b1;
    endfunction

    // ----------------------------------------------------------------
    // Link domain: shift edges counted from the select fall
    // ----------------------------------------------------------------
    logic [CW-1:0] lcnt_ff;
    logic [CW-1:0] lgray_ff;
    logic          rdy_meta_ff;
    logic          rdy_sync_ff;
    logic [RW-1:0] sh_ff;
    logic          sdo_ff;
    logic [CW-1:0] nxt_lcnt;
    logic [RW-1:0] nxt_sh;
    logic          nxt_sdo;
    logic [RW-1:0] hold_code_ff;
    logic          word_rdy_ff;
    logic [RW-1:0] link_word;
    logic          load_msb;

    // Counter saturates at a full frame; gray copy crosses to clk_sys
    assign nxt_lcnt  = (lcnt_ff == sacpd_pkg::FRAME_EDGES) ?
                       lcnt_ff : lcnt_ff + 1'b1;
    assign load_msb  = (lcnt_ff == sacpd_pkg::LEAD_LOAD);
    // Hold word is stable while its ready level stands
    assign link_word = rdy_sync_ff ? hold_code_ff : '0;
    assign nxt_sdo   = load_msb ? link_word[RW-1] : sh_ff[RW-1];
    assign nxt_sh    = load_msb ? {link_word[RW-2:0], 1'b0} :
                                  {sh_ff[RW-2:0], 1'b0};

    // Select high ends the frame and clears all link state
    always_ff @(negedge sclk or posedge cs_b)
    begin
        if (cs_b)
        begin
            lcnt_ff     <= '0;
            lgray_ff    <= '0;
            rdy_meta_ff <= 1'b0;
            rdy_sync_ff <= 1'b0;
            sh_ff       <= '0;
            sdo_ff      <= 1'b0;
        end
        else
        begin
            lcnt_ff     <= nxt_lcnt;
            lgray_ff    <= nxt_lcnt ^ (nxt_lcnt >> 1);
            rdy_meta_ff <= word_rdy_ff;
            rdy_sync_ff <= rdy_meta_ff;
            sh_ff       <= nxt_sh;
            sdo_ff      <= nxt_sdo;
        end
    end

    // Output driven only inside a frame; released when select rises
    assign serial_data_out  = sdo_ff;
    assign serial_data_oe_b = cs_b;

    // ----------------------------------------------------------------
    // System domain: synchronisers
    // ----------------------------------------------------------------
    logic          cs_s1_ff;
    logic          cs_s2_ff;
    logic          cs_s3_ff;
    logic [CW-1:0] gray_s1_ff;
    logic [CW-1:0] gray_s2_ff;
    logic [CW-1:0] gray_d1_ff;
    logic [CW-1:0] gray_d2_ff;

    // Count is delayed two more stages so a late select sync still
    // sees the count from before the frame-end clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cs_s1_ff   <= 1'b1;
            cs_s2_ff   <= 1'b1;
            cs_s3_ff   <= 1'b1;
            gray_s1_ff <= '0;
            gray_s2_ff <= '0;
            gray_d1_ff <= '0;
            gray_d2_ff <= '0;
        end
        else
        begin
            cs_s1_ff   <= cs_b;
            cs_s2_ff   <= cs_s1_ff;
            cs_s3_ff   <= cs_s2_ff;
            gray_s1_ff <= lgray_ff;
            gray_s2_ff <= gray_s1_ff;
            gray_d1_ff <= gray_s2_ff;
            gray_d2_ff <= gray_d1_ff;
        end
    end

    // ----------------------------------------------------------------
    // System domain: frame decode
    // ----------------------------------------------------------------
    wire           cs_fall = cs_s3_ff & ~cs_s2_ff;
    wire           cs_rise = ~cs_s3_ff & cs_s2_ff;
    wire  [CW-1:0] fcnt    = gray2bin(gray_d2_ff);
    wire  [CW-1:0] live    = gray2bin(gray_s2_ff);
    wire           pd_win  = (fcnt >= sacpd_pkg::PD_LO_EDGE) &&
                             (fcnt < sacpd_pkg::PD_HI_EDGE);
    wire           awake   = (fcnt >= sacpd_pkg::WAKE_EDGE);
    wire           full    = (fcnt >= sacpd_pkg::FRAME_EDGES);
    wire           woke16  = (live >= sacpd_pkg::FRAME_EDGES);

    // ----------------------------------------------------------------
    // System domain: power mode
    // ----------------------------------------------------------------
    sacpd_pkg::sacpd_mode_e mode_ff;
    sacpd_pkg::sacpd_mode_e nxt_mode;
    logic                   ready_ff;
    logic                   nxt_ready;

    // Mode picked from the edge count at the select rise; power-down goes to wake at the select fall
    always_comb
    begin
        nxt_mode = mode_ff;
        case (mode_ff)
            sacpd_pkg::SACPD_NORMAL:
            begin
                if (cs_rise && pd_win)
                begin
                    nxt_mode = sacpd_pkg::SACPD_PDOWN;
                end
            end
            sacpd_pkg::SACPD_PDOWN:
            begin
                if (cs_fall)
                begin
                    nxt_mode = sacpd_pkg::SACPD_WAKE;
                end
            end
            sacpd_pkg::SACPD_WAKE:
            begin
                if (cs_rise && awake)
                begin
                    nxt_mode = sacpd_pkg::SACPD_NORMAL;
                end
                else if (cs_rise)
                begin
                    nxt_mode = sacpd_pkg::SACPD_PDOWN;
                end
            end
            default:
            begin
                nxt_mode = sacpd_pkg::SACPD_NORMAL;
            end
        endcase
    end

    // Fully powered after a full dummy frame of edges
    assign nxt_ready = (nxt_mode == sacpd_pkg::SACPD_NORMAL) ||
                       ((mode_ff == sacpd_pkg::SACPD_WAKE) &&
                        (woke16 || ready_ff));

    // Mode and readiness registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            mode_ff  <= sacpd_pkg::SACPD_NORMAL;
            ready_ff <= 1'b1;
        end
        else
        begin
            mode_ff  <= nxt_mode;
            ready_ff <= nxt_ready & (nxt_mode != sacpd_pkg::SACPD_PDOWN);
        end
    end

    assign power_mode  = mode_ff;
    assign power_on    = (mode_ff != sacpd_pkg::SACPD_PDOWN);
    assign power_ready = ready_ff;

    // ----------------------------------------------------------------
    // System domain: conversion and throughput check
    // ----------------------------------------------------------------
    logic             conv_act_ff;
    logic             late_ff;
    logic             rate_err_ff;
    logic [sacpd_pkg::GAP_W-1:0] gap_ff;
    wire              start_conv = cs_fall &&
                                   (mode_ff == sacpd_pkg::SACPD_NORMAL);
    wire              too_soon   = gap_ff < sacpd_pkg::MIN_FRAME_CNT;
    wire              push       = cs_rise && conv_act_ff && full &&
                                   (mode_ff == sacpd_pkg::SACPD_NORMAL);
    logic             in_ready;

    // Capture on the select fall; a wake frame converts nothing
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            hold_code_ff <= '0;
            conv_act_ff  <= 1'b0;
            word_rdy_ff  <= 1'b0;
        end
        else if (start_conv)
        begin
            hold_code_ff <= sample_code;
            conv_act_ff  <= 1'b1;
            word_rdy_ff  <= 1'b1;
        end
        else if (cs_rise)
        begin
            conv_act_ff  <= 1'b0;
            word_rdy_ff  <= 1'b0;
        end
    end

    // Frame spacing counter; saturates at the least frame period
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            gap_ff      <= sacpd_pkg::GAP_RST;
            late_ff     <= 1'b0;
            rate_err_ff <= 1'b0;
        end
        else
        begin
            gap_ff      <= cs_fall ? '0 :
                           (too_soon ? gap_ff + 1'b1 : gap_ff);
            late_ff     <= cs_fall ? too_soon : late_ff;
            rate_err_ff <= cs_fall & too_soon;
        end
    end

    assign rate_err = rate_err_ff;

    // ----------------------------------------------------------------
    // Result buffer
    // ----------------------------------------------------------------
    sacpd_pkg::sacpd_result_s mem_ff [DEPTH];
    sacpd_pkg::sacpd_result_s push_word;
    logic [AW-1:0]            wr_ptr_ff;
    logic [AW-1:0]            rd_ptr_ff;
    logic [AW:0]              cnt_ff;
    logic                     ovr_ff;
    wire                      do_push = push & in_ready;
    wire                      do_pop  = result_valid & result_ready;

    assign in_ready       = (cnt_ff != (AW+1)'(DEPTH));
    assign result_valid   = (cnt_ff != '0);
    assign result_data    = mem_ff[rd_ptr_ff];
    assign push_word.late = late_ff;
    assign push_word.code = hold_code_ff;

    // One storage word per entry
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge clk_sys)
        begin
            if (!rst_b)
            begin
                mem_ff[i] <= '0;
            end
            else if (do_push && (wr_ptr_ff == AW'(i)))
            begin
                mem_ff[i] <= push_word;
            end
        end
    end

    // Pointers, fill level and overrun pulse
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
            ovr_ff    <= 1'b0;
        end
        else
        begin
            wr_ptr_ff <= do_push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
            rd_ptr_ff <= do_pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
            cnt_ff    <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
            ovr_ff    <= push & ~in_ready;
        end
    end

    assign conv_overrun = ovr_ff;

endmodule

// ===== rtl/sacpd_pkg.sv
// Constants and types of the serial converter and power-mode controller.
// Assumes a 40 MHz system clock and a host that makes the shift clock.
package sacpd_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int RES_BITS = 12;              // Result width
    localparam int CNT_W    = 5;               // Shift-edge counter width
    localparam logic [CNT_W-1:0] LEAD_LOAD   = 5'h03; // Edge 4 loads MSB
    localparam logic [CNT_W-1:0] PD_LO_EDGE  = 5'h02; // Power-down window
    localparam logic [CNT_W-1:0] PD_HI_EDGE  = 5'h0a; // Window closes
    localparam logic [CNT_W-1:0] WAKE_EDGE   = 5'h0a; // Dummy frame length
    localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h10; // Full frame, 16

    // ----------------------------------------------------------------
    // Throughput limit
    // ----------------------------------------------------------------
    localparam int CLK_KHZ       = 40000;      // System clock rate
    localparam int THRU_KSPS     = 250;        // Highest frame rate
    localparam int MIN_FRAME_CYC = CLK_KHZ / THRU_KSPS;
    localparam int GAP_W         = 8;
    localparam logic [GAP_W-1:0] MIN_FRAME_CNT = GAP_W'(MIN_FRAME_CYC);
    localparam logic [GAP_W-1:0] GAP_RST       = GAP_W'(MIN_FRAME_CYC);

    // ----------------------------------------------------------------
    // Buffer
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SACPD_NORMAL,
        SACPD_PDOWN,
        SACPD_WAKE
    } sacpd_mode_e;

    typedef struct packed {
        logic                late;   // Frame began too soon
        logic [RES_BITS-1:0] code;   // Conversion result
    } sacpd_result_s;

endpackage

// ===== testbench/sacpd_core_monitor.sv
// Concurrent checks on the ports of the converter control core.
// Assumes link pins are looked at on clk_sys, rst_b active low.
`timescale 1ns/1ps

module sacpd_core_monitor #(
    parameter int DEPTH = 2
) (
    input wire logic                     clk_sys,
    input wire logic                     rst_b,
    input wire logic                     sclk,
    input wire logic                     cs_b,
    input wire logic [11:0]              sample_code,
    input wire logic                     result_ready,
    input wire logic                     result_valid,
    input wire sacpd_pkg::sacpd_result_s result_data,
    input wire logic                     serial_data_out,
    input wire logic                     serial_data_oe_b,
    input wire logic                     power_on,
    input wire logic                     power_ready,
    input wire sacpd_pkg::sacpd_mode_e   power_mode,
    input wire logic                     conv_overrun,
    input wire logic                     rate_err
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    property p_oe_follows;
        serial_data_oe_b == cs_b;
    endproperty
    a_oe_follows: assert property (p_oe_follows)
        else $error("output enable differs from select");

    property p_sdo_idle;
        cs_b |-> !serial_data_out;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle)
        else $error("serial data not idle with select high");

    property p_pd_off;
        power_mode == sacpd_pkg::SACPD_PDOWN |-> !power_on && !power_ready;
    endproperty
    a_pd_off: assert property (p_pd_off)
        else $error("converter biased in power-down");

    property p_wake;
        power_mode == sacpd_pkg::SACPD_PDOWN && $fell(cs_b)
            |-> ##[1:6] power_mode == sacpd_pkg::SACPD_WAKE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no power-up after select fall");

    property p_wake_src;
        $rose(power_mode == sacpd_pkg::SACPD_WAKE)
            |-> $past(power_mode) == sacpd_pkg::SACPD_PDOWN;
    endproperty
    a_wake_src: assert property (p_wake_src)
        else $error("power-up entered from normal mode");

    property p_pd_entry;
        $rose(power_mode == sacpd_pkg::SACPD_PDOWN) |-> cs_b && $past(cs_b, 2);
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down without select rise");

    property p_hold;
        result_valid && !result_ready |=> result_valid && $stable(result_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed while stalled");

    property p_push;
        $rose(result_valid)
            |-> cs_b && power_ready && power_mode == sacpd_pkg::SACPD_NORMAL;
    endproperty
    a_push: assert property (p_push)
        else $error("result pushed outside a full normal frame");
endmodule

bind sacpd_core sacpd_core_monitor #(.DEPTH(DEPTH)) i_sacpd_core_monitor (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .sample_code(sample_code), .result_ready(result_ready),
    .result_valid(result_valid), .result_data(result_data),
    .serial_data_out(serial_data_out), .serial_data_oe_b(serial_data_oe_b),
    .power_on(power_on), .power_ready(power_ready),
    .power_mode(power_mode), .conv_overrun(conv_overrun),
    .rate_err(rate_err)
);

// ===== testbench/sacpd_host.sv
// Host-side serial controller model: makes select and the shift clock.
// Assumes the converter shifts one bit out on each shift falling edge.
`timescale 1ns/1ps

module sacpd_host (
    output logic        cs_b,
    output logic        sclk,
    input  wire         sdo,
    output logic [15:0] rx
);
    // Idle: select high, shift clock parked high between frames
    initial
    begin
        cs_b = 1'b1;
        sclk = 1'b1;
        rx   = 16'h0000;
    end

    // One frame of n shift falling edges at 160 ns, then select rises
    task automatic frame(input int n);
        rx   = 16'h0000;
        cs_b = 1'b0;
        #97;
        for (int k = 0; k < n; k++)
        begin
            rx   = {rx[14:0], sdo};
            sclk = 1'b0;
            #80;
            sclk = 1'b1;
            #80;
        end
        cs_b = 1'b1;
    endtask
endmodule

// ===== testbench/tb_sacpd_core.sv
// Self-checking bench of the converter control core.
// Assumes the host model drives select and shift clock.
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end

module tb_sacpd_core;
    logic                     clk_sys, rst_b, cs_b, sclk, stall;
    logic                     result_ready, result_valid, rate_err;
    logic                     serial_data_out, serial_data_oe_b;
    logic                     power_on, power_ready, conv_overrun;
    logic [11:0]              sample_code;
    logic [15:0]              host_rx;
    wire                      sdo_pin;
    sacpd_pkg::sacpd_result_s result_data, got_w;
    sacpd_pkg::sacpd_result_s exp_q[$];
    sacpd_pkg::sacpd_mode_e   power_mode;
    int                       fail_count, num_checks, ovr_n, exp_ovr, mode;
    int                       rate_n, exp_rate;
    realtime                  last_fall;
    int                       seq[11] = '{0, 1, 2, 9, 8, 10, 16, 9, 16, 16, 15};

    sacpd_core #(.DEPTH(2)) i_sacpd_core (
        .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
        .sample_code(sample_code), .result_ready(result_ready),
        .result_valid(result_valid), .result_data(result_data),
        .serial_data_out(serial_data_out),
        .serial_data_oe_b(serial_data_oe_b), .power_on(power_on),
        .power_ready(power_ready), .power_mode(power_mode),
        .conv_overrun(conv_overrun), .rate_err(rate_err)
    );

    // Released data line floats
    assign sdo_pin = serial_data_oe_b ? 1'bz : serial_data_out;

    sacpd_host i_sacpd_host (
        .cs_b(cs_b), .sclk(sclk), .sdo(sdo_pin), .rx(host_rx)
    );

    // System clock, 25 ns
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Sink ready: random, forced low while stalling
    always @(posedge clk_sys)
        result_ready <= #2 !stall && ($urandom_range(1, 0) == 1);

    // Popped words against the model queue; count dropped words
    always @(posedge clk_sys)
    begin
        if (rst_b && result_valid === 1'b1 && result_ready === 1'b1)
        begin
            got_w = exp_q.pop_front();
            `CHK(result_data, got_w)
        end
        if (conv_overrun === 1'b1)
            ovr_n++;
        if (rst_b && rate_err === 1'b1)
            rate_n++;
    end

    // Prints the counts and the verdict, then ends the run
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One frame of n edges, model update, then mode checks after the gap
    task automatic run(input int n, input int gap, input logic st = 1'b0);
        logic                   late;
        logic [11:0]            code;
        int                     m0;
        sacpd_pkg::sacpd_mode_e em;
        code = 12'($urandom);
        @(posedge clk_sys);
        #2;
        sample_code = code;
        stall = st;
        late = ($realtime - last_fall) < 4000.0;
        last_fall = $realtime;
        if (late)
            exp_rate++;
        m0 = mode;
        if (gap < 0)
            gap = 4100 - 160 * n;
        i_sacpd_host.frame(n);
        if (m0 == 0 && n == 16)
            `CHK(host_rx, {4'h0, code})
        if (m0 != 0)
            `CHK(host_rx, 16'h0000)
        if (m0 == 1)
            mode = (n >= 10) ? 0 : 1;
        else if (n >= 2 && n <= 9)
            mode = 1;
        else if (n >= 16 && exp_q.size() == 2)
            exp_ovr++;
        else if (n >= 16)
            exp_q.push_back({late, code});
        #gap;
        em = (mode == 1) ? sacpd_pkg::SACPD_PDOWN
                         : sacpd_pkg::SACPD_NORMAL;
        `CHK(power_mode, em)
        `CHK(power_on, mode != 1)
        `CHK(power_ready, mode != 1)
        `CHK(ovr_n, exp_ovr)
        `CHK(rate_n, exp_rate)
    endtask

    // Watchdog well past the expected run length
    initial
    begin
        #500000;
        fail_count++;
        close_out();
    end

    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        stall = 1'b0;
        result_ready = 1'b0;
        sample_code = 12'h000;
        fail_count = 0;
        num_checks = 0;
        ovr_n = 0;
        exp_ovr = 0;
        rate_n = 0;
        exp_rate = 0;
        mode = 0;
        last_fall = -1.0e6;
        void'($urandom(32'hd731));
        repeat (10) @(posedge clk_sys);
        #2 rst_b = 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK(power_ready, 1'b1)
        repeat (3) run(16, -1);
        $display("test normal frames done");
        foreach (seq[i]) run(seq[i], -1);
        $display("test power modes done");
        repeat (3) run(16, -1, 1'b1);
        `CHK(result_valid, 1'b1)
        run(16, -1);
        $display("test buffer done");
        run(16, 200);
        run(16, -1);
        repeat (60) @(posedge clk_sys);
        `CHK(result_valid, 1'b0)
        `CHK(exp_q.size(), 0)
        $display("test frame rate done");
        close_out();
    end
endmodule
